// ===== core/cawd_defines.vh
// Purpose: Shared constants for the counter array watchdog block
// Assumes: Included by bare name from core design and verif files
// Notes:   Definitions only
`ifndef CAWD_DEFINES_VH
`define CAWD_DEFINES_VH

`define CAWD_CPS_W        3
`define CAWD_CPS_DIV12    3'h0
`define CAWD_CPS_SYSTEM_CLOCK   3'h1
`define CAWD_CPS_DIV4     3'h2
`define CAWD_CPS_EXT      3'h3
`define CAWD_DIV_W        4
`define CAWD_DIV12_LAST   4'hb
`define CAWD_DIV4_LAST    4'h3
`define CAWD_DIV_ZERO     4'h0
`define CAWD_DIV_ONE      4'h1
`define CAWD_BYTE_ZERO    8'h00
`define CAWD_BYTE_ONE     8'h01
`define CAWD_BYTE_MAX     8'hff
`define CAWD_MODE_ZERO    8'h00
`define CAWD_MODE_SWTIMER 8'h48
`define CAWD_RST_W        2
`define CAWD_RST_ZERO     2'h0
`define CAWD_RST_ONE      2'h1
`define CAWD_RST_PULSE    2'h2

`endif

// ===== core/cawd_prescale.v
// Purpose: Counter array clock tick generator from the clock source select
// Assumes: One clock, synchronous active-low reset
// Notes:   Emits a one-cycle tick per counter clock
`timescale 1ns/10ps
`default_nettype none
`include "cawd_defines.vh"

module cawd_prescale (
    // Clock and reset
    input  wire                    mclk_in,
    input  wire                    rst_n_in,
    // Control
    input  wire [`CAWD_CPS_W-1:0]  cps_in,
    input  wire                    ext_tick_in,
    input  wire                    run_in,
    // Tick
    output reg                     tick_out
);

    reg [`CAWD_DIV_W-1:0] div_r;
    reg [`CAWD_DIV_W-1:0] last;

    always @* begin
        if (cps_in == `CAWD_CPS_DIV4) begin
            last = `CAWD_DIV4_LAST;
        end else begin
            last = `CAWD_DIV12_LAST;
        end
    end

    // Divider free-runs so a stopped counter resumes on a clean phase
    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            div_r    <= `CAWD_DIV_ZERO;
            tick_out <= 1'b0;
        end else begin
            if (div_r >= last) begin
                div_r <= `CAWD_DIV_ZERO;
            end else begin
                div_r <= div_r + `CAWD_DIV_ONE;
            end
            if (!run_in) begin
                tick_out <= 1'b0;
            end else if (cps_in == `CAWD_CPS_SYSTEM_CLOCK) begin
                tick_out <= 1'b1;
            end else if (cps_in == `CAWD_CPS_EXT) begin
                tick_out <= ext_tick_in;
            end else begin
                tick_out <= (div_r >= last);
            end
        end
    end

endmodule
`default_nettype wire

// ===== core/cawd_watchdog.v
// Purpose: Watchdog mode of counter array module 5 with its counter and locks
// Assumes: Software writes arrive as one-cycle strobes with a data byte
// Notes:   Only the watchdog use of module 5 is built; other modes are absent
// Notes on behaviour
// RULE_01 Watchdog enable bit makes module 5 act as watchdog.
// RULE_02 Compare high byte matches counter high; low byte holds refresh offset.
// RULE_03 Watchdog comes out of every reset enabled.
// RULE_04 Watchdog enabled forces counter running; run bit writes no effect.
// RULE_05 Counter low and high byte writes ignored while watchdog enabled.
// RULE_06 Clock source select and idle suspend frozen while enabled.
// RULE_07 Module 5 forced to software timer; its mode writes disabled.
// RULE_08 Run bit reads zero if software never set it, despite running.
// RULE_09 Compare high write loads counter high plus offset byte.
// RULE_10 Reset when low byte overflows while compare high equals counter high.
// RULE_11 Writing 1 to module 5 flag forces watchdog reset when enabled.
// RULE_12 Enable or lock bit enables; lock holds until next reset.
// RULE_13 Lock clear: clearing enable bit disables and releases freezes.
// RULE_14 Reset defaults: divide by 12, low byte and offset zero.
// RULE_15 Timeout is 256 times offset plus 256 minus low byte.
// RULE_16 Idle suspend bit stops counting while CPU idles.
// RULE_17 Software disables, configures, enables, then writes compare high.
// RULE_18 Software not using the watchdog disables it early.
// RULE_19 Outside watchdog, run bit starts and stops the counter.
// RULE_20 Watchdog reset leaves as a registered pulse of system clock cycles.
// RULE_21 Every reset, watchdog one included, restores enabled and unlocked.
`timescale 1ns/10ps
`default_nettype none
`include "cawd_defines.vh"

module cawd_watchdog (
    // Clock and reset
    input  wire                    mclk_in,
    input  wire                    rst_n_in,
    // Mode register writes
    input  wire                    md_wr_in,
    input  wire                    md_wd_enable_in,
    input  wire                    md_wd_lock_in,
    input  wire                    md_idle_suspend_in,
    input  wire [`CAWD_CPS_W-1:0]  md_cps_in,
    // Control register writes
    input  wire                    cn_wr_in,
    input  wire                    cn_run_in,
    input  wire                    cn_flag5_in,
    // Counter byte writes
    input  wire                    cnt_lo_wr_in,
    input  wire                    cnt_hi_wr_in,
    // Module 5 writes
    input  wire                    cmp_lo_wr_in,
    input  wire                    cmp_hi_wr_in,
    input  wire                    mode5_wr_in,
    input  wire [7:0]              wdata_in,
    // System status
    input  wire                    cpu_idle_in,
    input  wire                    ext_tick_in,
    // Status and readback
    output wire                    wd_active_out,
    output reg                     wd_enable_out,
    output reg                     wd_lock_out,
    output reg                     idle_suspend_out,
    output reg  [`CAWD_CPS_W-1:0]  cps_out,
    output wire                    run_read_out,
    output wire                    counting_out,
    output reg  [7:0]              cnt_lo_out,
    output reg  [7:0]              cnt_hi_out,
    output reg  [7:0]              cmp_lo_out,
    output reg  [7:0]              cmp_hi_out,
    output wire [7:0]              mode5_out,
    // Reset request
    output reg                     wd_reset_out
);

    reg                    run_sw_r;
    reg  [7:0]             mode5_r;
    reg  [`CAWD_RST_W-1:0] rst_cnt_r;
    wire                   tick;
    wire                   wd_on;
    wire                   lo_ovf;
    wire                   fire;

    function [7:0] byte_inc;
        input [7:0] b;
        begin
            byte_inc = b + `CAWD_BYTE_ONE;
        end
    endfunction

    assign wd_on = wd_enable_out | wd_lock_out; // RULE_12
    assign wd_active_out = wd_on; // RULE_01
    // Enabled watchdog overrides the run bit
    assign counting_out = (wd_on | run_sw_r) & ~(idle_suspend_out & cpu_idle_in); // RULE_04 RULE_19 RULE_16
    assign run_read_out = run_sw_r; // RULE_08
    assign mode5_out = wd_on ? `CAWD_MODE_SWTIMER : mode5_r; // RULE_07
    assign lo_ovf = tick & (cnt_lo_out == `CAWD_BYTE_MAX);
    // Match of compare high and counter high at low byte wrap, or a forced flag 5 write
    assign fire = wd_on & ((lo_ovf & (cmp_hi_out == cnt_hi_out)) // RULE_10 RULE_02 RULE_15
                 | (cn_wr_in & cn_flag5_in)); // RULE_11

    cawd_prescale u_prescale (
        .mclk_in     (mclk_in),
        .rst_n_in    (rst_n_in),
        .cps_in      (cps_out),
        .ext_tick_in (ext_tick_in),
        .run_in      (counting_out),
        .tick_out    (tick)
    );

    // Mode register and enable/lock
    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            wd_enable_out    <= 1'b1; // RULE_03 RULE_21
            wd_lock_out      <= 1'b0; // RULE_21
            idle_suspend_out <= 1'b0;
            cps_out          <= `CAWD_CPS_DIV12; // RULE_14
        end else if (md_wr_in) begin
            if (!wd_lock_out) begin
                wd_enable_out <= md_wd_enable_in; // RULE_13
            end
            // Lock is sticky; only reset clears it
            wd_lock_out <= wd_lock_out | md_wd_lock_in; // RULE_12
            if (!wd_on) begin
                idle_suspend_out <= md_idle_suspend_in; // RULE_06
                cps_out          <= md_cps_in; // RULE_06
            end
        end
    end

    // Run bit and module 5 mode
    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            run_sw_r <= 1'b0;
            mode5_r  <= `CAWD_MODE_ZERO;
        end else begin
            if (cn_wr_in) begin
                run_sw_r <= cn_run_in; // RULE_19
            end
            if (mode5_wr_in && !wd_on) begin
                mode5_r <= wdata_in; // RULE_07
            end
        end
    end

    // Counter, writes blocked while the watchdog runs
    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            cnt_lo_out <= `CAWD_BYTE_ZERO; // RULE_14
            cnt_hi_out <= `CAWD_BYTE_ZERO;
        end else if (cnt_lo_wr_in && !wd_on) begin
            cnt_lo_out <= wdata_in; // RULE_05
        end else if (cnt_hi_wr_in && !wd_on) begin
            cnt_hi_out <= wdata_in; // RULE_05
        end else if (tick) begin
            cnt_lo_out <= byte_inc(cnt_lo_out);
            if (lo_ovf) begin
                cnt_hi_out <= byte_inc(cnt_hi_out);
            end
        end
    end

    // Module 5 bytes
    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            cmp_lo_out <= `CAWD_BYTE_ZERO; // RULE_14
            cmp_hi_out <= `CAWD_BYTE_ZERO;
        end else begin
            if (cmp_lo_wr_in) begin
                cmp_lo_out <= wdata_in; // RULE_02
            end
            if (cmp_hi_wr_in && wd_on) begin
                // Refresh ignores the written value
                cmp_hi_out <= cnt_hi_out + cmp_lo_out; // RULE_09
            end else if (cmp_hi_wr_in) begin
                cmp_hi_out <= wdata_in;
            end
        end
    end

    // Stretched reset pulse so the system reset logic cannot miss it
    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            rst_cnt_r    <= `CAWD_RST_ZERO;
            wd_reset_out <= 1'b0;
        end else if (fire) begin
            rst_cnt_r    <= `CAWD_RST_PULSE; // RULE_20
            wd_reset_out <= 1'b1;
        end else if (rst_cnt_r != `CAWD_RST_ZERO) begin
            rst_cnt_r    <= rst_cnt_r - `CAWD_RST_ONE;
            wd_reset_out <= (rst_cnt_r != `CAWD_RST_ONE);
        end else begin
            wd_reset_out <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ===== verif/cawd_watchdog_checker.sv
// Purpose: Port-level checks of the counter array watchdog
// Assumes: Bound to cawd_watchdog, one clock domain
// Notes:   Count values checked only where no tick can race
`timescale 1ns/10ps
`default_nettype none
`include "cawd_defines.vh"
module cawd_watchdog_checker (
    // Watched inputs
    input wire logic       mclk_in, rst_n_in, cn_wr_in, cn_flag5_in,
    input wire logic       cnt_hi_wr_in, cmp_hi_wr_in, cpu_idle_in,
    // Watched outputs
    input wire logic       wd_active_out, wd_enable_out, wd_lock_out,
    input wire logic       idle_suspend_out, counting_out, wd_reset_out,
    input wire logic [2:0] cps_out,
    input wire logic [7:0] cnt_lo_out, cnt_hi_out, cmp_lo_out, cmp_hi_out, mode5_out
);
    wire [7:0] refresh_val = cnt_hi_out + cmp_lo_out;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    property p_run; wd_active_out |-> counting_out == !(idle_suspend_out && cpu_idle_in); endproperty
    a_run: assert property (p_run) else $error("counter not forced on");
    property p_lock; wd_lock_out |=> wd_lock_out && wd_active_out; endproperty
    a_lock: assert property (p_lock) else $error("lock released");
    property p_frz; wd_active_out |=> $stable(cps_out) && $stable(idle_suspend_out); endproperty
    a_frz: assert property (p_frz) else $error("source or idle changed");
    property p_md5; wd_active_out |-> mode5_out == `CAWD_MODE_SWTIMER; endproperty
    a_md5: assert property (p_md5) else $error("module 5 mode not forced");
    property p_chi; wd_active_out && cnt_hi_wr_in && cnt_lo_out != 8'hff |=> $stable(cnt_hi_out); endproperty
    a_chi: assert property (p_chi) else $error("counter high written");
    property p_ref; wd_active_out && cmp_hi_wr_in |=> cmp_hi_out == $past(refresh_val); endproperty
    a_ref: assert property (p_ref) else $error("bad refresh value");
    property p_frc; wd_active_out && cn_wr_in && cn_flag5_in |=> wd_reset_out [*2] ##1 !wd_reset_out; endproperty
    a_frc: assert property (p_frc) else $error("forced reset pulse wrong");
    property p_ovf; wd_active_out && cmp_hi_out == cnt_hi_out && cnt_lo_out == 8'hff
        |=> cnt_lo_out != 8'h00 || wd_reset_out; endproperty
    a_ovf: assert property (p_ovf) else $error("overflow match without reset");
    property p_def; $rose(rst_n_in) |-> wd_enable_out && !wd_lock_out && cps_out == 3'h0
        && cnt_lo_out == 8'h00 && cmp_lo_out == 8'h00; endproperty
    a_def: assert property (p_def) else $error("bad reset defaults");
    c_fire: cover property (wd_reset_out);
    c_ref: cover property (wd_active_out && cmp_hi_wr_in);
    c_idle: cover property (wd_active_out && !counting_out);
endmodule
bind cawd_watchdog cawd_watchdog_checker u_chk (.*);
`default_nettype wire

// ===== verif/test_counter_array_watchdog.sv
// Purpose: Self-checking bench for the counter array watchdog
// Assumes: Writes are one-cycle strobes launched 1 ns after an edge
// Notes:   Tick source 3 left idle; timeout run on the system clock
`timescale 1ns/10ps
`default_nettype none
`include "cawd_defines.vh"
module test_counter_array_watchdog;
    localparam logic [6:0] MD = 7'h40, CN = 7'h20, CLO = 7'h10, CHI = 7'h08, PLO = 7'h04, PHI = 7'h02, M5 = 7'h01;
    logic       mclk_in, rst_n_in, md_wd_enable_in, md_wd_lock_in, md_idle_suspend_in, cn_run_in, cn_flag5_in;
    logic       cpu_idle_in, ext_tick_in;
    logic [2:0] md_cps_in;
    logic [7:0] wdata_in, lo_seen, hi_seen;
    logic [6:0] stb;
    wire        md_wr_in, cn_wr_in, cnt_lo_wr_in, cnt_hi_wr_in, cmp_lo_wr_in, cmp_hi_wr_in, mode5_wr_in;
    wire        wd_active_out, wd_enable_out, wd_lock_out, idle_suspend_out, run_read_out, counting_out, wd_reset_out;
    wire [2:0]  cps_out;
    wire [7:0]  cnt_lo_out, cnt_hi_out, cmp_lo_out, cmp_hi_out, mode5_out;
    int         error_cnt = 0, samples_checked = 0, n;
    assign {md_wr_in, cn_wr_in, cnt_lo_wr_in, cnt_hi_wr_in, cmp_lo_wr_in, cmp_hi_wr_in, mode5_wr_in} = stb;
    cawd_watchdog DUT (.*);
    initial begin
        mclk_in = 0;
        forever #5 mclk_in = ~mclk_in;
    end
    task automatic chk(input string nm, input logic [15:0] s, e);
        samples_checked++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [6:0] s, input logic [7:0] d);
        @(posedge mclk_in);
        #1;
        stb = s;
        wdata_in = d;
        {md_wd_enable_in, md_wd_lock_in, md_idle_suspend_in, md_cps_in} = d[5:0];
        {cn_run_in, cn_flag5_in} = d[1:0];
        lo_seen = cnt_lo_out;
        hi_seen = cnt_hi_out;
        @(posedge mclk_in);
        #1;
        stb = 7'h00;
    endtask
    task automatic do_reset;
        rst_n_in = 0;
        repeat (8) @(posedge mclk_in);
        #1;
        rst_n_in = 1;
    endtask
    task automatic t_defaults;
        chk("enable", wd_enable_out, 1);
        chk("lock", wd_lock_out, 0);
        chk("cps", cps_out, 0);
        chk("offset", cmp_lo_out, 0);
        chk("run_read", run_read_out, 0);
        chk("counting", counting_out, 1);
    endtask
    task automatic t_blocked;
        wr(CLO, 8'h55);
        chk("cnt_lo_hit", cnt_lo_out === 8'h55, 0);
        wr(CHI, 8'h55);
        chk("cnt_hi_hit", cnt_hi_out, 0);
        wr(MD, 8'h29);
        chk("cps_frozen", cps_out, 0);
        chk("idle_frozen", idle_suspend_out, 0);
        wr(M5, 8'h00);
        chk("mode5", mode5_out, `CAWD_MODE_SWTIMER);
        wr(CN, 8'h00);
        chk("forced_run", counting_out, 1);
        wr(CN, 8'h02);
        chk("run_read", run_read_out, 1);
    endtask
    task automatic t_timeout;
        wr(CN, 8'h00);
        wr(MD, 8'h01);
        wr(MD, 8'h01);
        chk("cps_free", cps_out, 1);
        chk("stopped", counting_out, 0);
        wr(CLO, 8'hf0);
        wr(CHI, 8'h00);
        wr(PLO, 8'h01);
        chk("cnt_lo_free", cnt_lo_out, 8'hf0);
        wr(MD, 8'h21);
        repeat (3) @(posedge mclk_in);
        wr(PHI, 8'h00);
        chk("refresh", cmp_hi_out, hi_seen + 8'h01);
        n = 1;
        while (wd_reset_out !== 1'b1 && n < 1000) begin
            @(posedge mclk_in);
            #1;
            n++;
        end
        chk("timeout", n, 16'd512 - lo_seen);
        @(posedge mclk_in);
        #1;
        chk("pulse_2nd", wd_reset_out, 1);
        @(posedge mclk_in);
        #1;
        chk("pulse_end", wd_reset_out, 0);
    endtask
    task automatic t_lock_force;
        wr(MD, 8'h10);
        wr(MD, 8'h00);
        chk("locked", wd_active_out, 1);
        wr(CN, 8'h01);
        chk("forced", wd_reset_out, 1);
        repeat (3) @(posedge mclk_in);
        #1;
    endtask
    task automatic t_idle;
        wr(MD, 8'h00);
        wr(MD, 8'h09);
        wr(MD, 8'h29);
        cpu_idle_in = 1;
        @(posedge mclk_in);
        #1;
        chk("idle_hold", counting_out, 0);
        cpu_idle_in = 0;
        @(posedge mclk_in);
        #1;
        chk("wake", counting_out, 1);
        wr(MD, 8'h00);
        chk("disabled", wd_active_out, 0);
        wr(CN, 8'h02);
        chk("run_on", counting_out, 1);
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        {rst_n_in, md_wd_enable_in, md_wd_lock_in, md_idle_suspend_in, cn_run_in, cn_flag5_in} = 6'h00;
        {cpu_idle_in, ext_tick_in, md_cps_in, wdata_in, stb} = 20'h00000;
        do_reset();
        t_defaults();
        t_blocked();
        t_timeout();
        do_reset();
        t_defaults();
        t_lock_force();
        do_reset();
        t_defaults();
        t_idle();
        conclude();
    end
    initial begin
        #100000;
        error_cnt++;
        conclude();
    end
endmodule
`default_nettype wire
